// ### src/eac_aux_regs.sv
// auxiliary control and status register bank with apb slave
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
module eac_aux_regs #(
  parameter int CHANNELS = 8,
  parameter int BREATH_PERIOD_CYC = eac_pkg::BREATH_BASE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] offPosRaw,
  input wire logic [7:0] offNegRaw,
  input wire logic fastRate,
  input wire logic [3:0] pinIn,
  output logic [3:0] pinOut,
  output logic [3:0] pinOe,
  output eac_pkg::eac_ctrl_t ctrl,
  output logic breathCtrlA,
  output logic breathCtrlB
);
  localparam logic [7:0] CH_MASK = 8'((1 << CHANNELS) - 1);

  logic [7:0] biasPos_q;
  logic [7:0] biasNeg_q;
  logic [7:0] offPosEn_q;
  logic [7:0] offNegEn_q;
  logic [7:0] offDir_q;
  logic [7:0] posStat_q;
  logic [7:0] negStat_q;
  logic [3:0] pinDir_q;
  logic [3:0] pinData_q;
  logic [7:0] pulse_q;
  logic [7:0] breath_q;
  logic [7:0] cfgFour_q;
  logic [5:0] regIdx;
  logic hit;
  logic xferDone;
  logic wrEn;
  logic [7:0] wByte;
  logic [7:0] readByte;
  logic [7:0] evenRoute;
  logic [7:0] oddRoute;
  logic [1:0] breathMode;
  logic pinsTaken;

  // ==========================================================
  // apb decode
  assign regIdx = paddr[7:2];
  assign hit = (paddr[1:0] == 2'b00) && (regIdx >= eac_pkg::IDX_BIAS_POS)
    && (regIdx <= eac_pkg::IDX_CONFIG_FOUR);
  // writes land only at the edge that completes the access phase
  assign xferDone = psel && penable && pready;
  assign wrEn = xferDone && pwrite && hit;
  assign wByte = pwdata[7:0];
  assign breathMode = breath_q[eac_pkg::MODE_LSB +: 2];
  assign pinsTaken = (breathMode == eac_pkg::MODE_EXT) || (breathMode == eac_pkg::MODE_RSV);

  // apb answer: one wait state, ready stands for one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !hit;
      // unmapped or misaligned reads return zero with an error
      prdata <= (hit && !pwrite) ? {24'h0, readByte} : 32'h0;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ==========================================================
  // per-channel selections; missing channels stay zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      biasPos_q <= eac_pkg::RST_ZERO;
    end else if (wrEn && regIdx == eac_pkg::IDX_BIAS_POS) begin
      biasPos_q <= wByte & CH_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      biasNeg_q <= eac_pkg::RST_ZERO;
    end else if (wrEn && regIdx == eac_pkg::IDX_BIAS_NEG) begin
      biasNeg_q <= wByte & CH_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      offPosEn_q <= eac_pkg::RST_ZERO;
    end else if (wrEn && regIdx == eac_pkg::IDX_OFF_POS_EN) begin
      offPosEn_q <= wByte & CH_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      offNegEn_q <= eac_pkg::RST_ZERO;
    end else if (wrEn && regIdx == eac_pkg::IDX_OFF_NEG_EN) begin
      offNegEn_q <= wByte & CH_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      offDir_q <= eac_pkg::RST_ZERO;
    end else if (wrEn && regIdx == eac_pkg::IDX_OFF_DIR) begin
      offDir_q <= wByte & CH_MASK;
    end
  end

  // ==========================================================
  // electrode-off status: sampled comparators, no write path at all
  // disabled channels read zero so a stale comparator cannot mislead
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      posStat_q <= eac_pkg::RST_ZERO;
      negStat_q <= eac_pkg::RST_ZERO;
    end else begin
      posStat_q <= offPosRaw & offPosEn_q & CH_MASK;
      negStat_q <= offNegRaw & offNegEn_q & CH_MASK;
    end
  end

  // ==========================================================
  // general pin port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinDir_q <= eac_pkg::RST_PIN_DIR;
    end else if (wrEn && regIdx == eac_pkg::IDX_PIN_PORT) begin
      pinDir_q <= wByte[3:0];
    end
  end

  // data bits take the write only where the pin is an output before the write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinData_q <= 4'h0;
    end else if (wrEn && regIdx == eac_pkg::IDX_PIN_PORT) begin
      pinData_q <= (pinData_q & pinDir_q)
        | (wByte[eac_pkg::PIN_DATA_LSB +: 4] & ~pinDir_q);
    end
  end

  // pin drivers; shared pins released while breathing owns them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOe <= 4'h0;
      pinOut <= 4'h0;
    end else begin
      pinOe <= ~pinDir_q & ~(pinsTaken ? eac_pkg::PIN_SHARED : 4'h0);
      pinOut <= pinData_q;
    end
  end

  // ==========================================================
  // pulse, breathing and config four registers; reserved bits kept zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_q <= eac_pkg::RST_PULSE;
    end else if (wrEn && regIdx == eac_pkg::IDX_PULSE_SEL) begin
      pulse_q <= wByte & eac_pkg::MASK_PULSE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      breath_q <= eac_pkg::RST_BREATHING;
    end else if (wrEn && regIdx == eac_pkg::IDX_BREATHING) begin
      breath_q <= wByte & eac_pkg::MASK_BREATHING;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgFour_q <= eac_pkg::RST_CONFIG_FOUR;
    end else if (wrEn && regIdx == eac_pkg::IDX_CONFIG_FOUR) begin
      cfgFour_q <= wByte & eac_pkg::MASK_CONFIG_FOUR;
    end
  end

  // ==========================================================
  // pulse routing: code k picks channel 2k+2 (even) or 2k+1 (odd)
  // a code naming a channel the variant lacks routes nothing
  for (genvar k = 0; k < 4; k++) begin : g_route
    assign evenRoute[2*k+1] = (pulse_q[eac_pkg::PULSE_EVEN_LSB +: 2] == 2'(k))
      && (2*k+1 < CHANNELS);
    assign evenRoute[2*k] = 1'b0;
    assign oddRoute[2*k] = (pulse_q[eac_pkg::PULSE_ODD_LSB +: 2] == 2'(k))
      && (2*k < CHANNELS);
    assign oddRoute[2*k+1] = 1'b0;
  end

  // control word toward the analog side, one register stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '0;
    end else begin
      ctrl.biasPos <= biasPos_q;
      ctrl.biasNeg <= biasNeg_q;
      ctrl.offPosEn <= offPosEn_q;
      ctrl.offNegEn <= offNegEn_q;
      ctrl.offDir <= offDir_q;
      ctrl.evenPulseCh <= evenRoute;
      ctrl.oddPulseCh <= oddRoute;
      ctrl.pulseBufOn <= pulse_q[eac_pkg::PULSE_ON_BIT];
      ctrl.breathMode <= breathMode;
      ctrl.breathPhase <= breath_q[eac_pkg::PHASE_LSB +: 3];
      ctrl.breathFreq <= cfgFour_q[eac_pkg::FREQ_LSB +: 3];
      ctrl.singleShot <= cfgFour_q[eac_pkg::SHOT_BIT];
      ctrl.terminalToBias <= cfgFour_q[eac_pkg::LINK_BIT];
      ctrl.comparatorOn <= cfgFour_q[eac_pkg::CMP_BIT];
    end
  end

  // ==========================================================
  // breathing control pair, runs only in mode 10
  eac_breath_gen #(
    .BASE_CYC(BREATH_PERIOD_CYC)
  ) u_breath (
    .clk(clk),
    .rst_n(rst_n),
    .enable(breathMode == eac_pkg::MODE_INT),
    .freqSel(cfgFour_q[eac_pkg::FREQ_LSB +: 3]),
    .phaseSel(breath_q[eac_pkg::PHASE_LSB +: 3]),
    // phase only at the top two frequencies and at 32 kSPS or faster
    .usePhase(fastRate
      && (cfgFour_q[eac_pkg::FREQ_LSB +: 3] <= eac_pkg::FREQ_PHASED_MAX)),
    .ctrlA(breathCtrlA),
    .ctrlB(breathCtrlB)
  );

  // ==========================================================
  // read mux
  always_comb begin
    unique case (regIdx)
      eac_pkg::IDX_BIAS_POS: readByte = biasPos_q;
      eac_pkg::IDX_BIAS_NEG: readByte = biasNeg_q;
      eac_pkg::IDX_OFF_POS_EN: readByte = offPosEn_q;
      eac_pkg::IDX_OFF_NEG_EN: readByte = offNegEn_q;
      eac_pkg::IDX_OFF_DIR: readByte = offDir_q;
      eac_pkg::IDX_OFF_POS_STAT: readByte = posStat_q;
      eac_pkg::IDX_OFF_NEG_STAT: readByte = negStat_q;
      eac_pkg::IDX_PIN_PORT: readByte = {pinIn, pinDir_q};
      eac_pkg::IDX_PULSE_SEL: readByte = pulse_q;
      eac_pkg::IDX_BREATHING: readByte = breath_q;
      eac_pkg::IDX_CONFIG_FOUR: readByte = cfgFour_q;
      default: readByte = 8'h00;
    endcase
  end

  // ==========================================================
  // checks
  apb_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not exactly one cycle after access");
  stat_track_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 posStat_q == ($past(offPosRaw) & $past(offPosEn_q) & CH_MASK))
    else $error("positive status not following enabled comparators");
  stat_wr_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrEn && (regIdx == eac_pkg::IDX_OFF_POS_STAT || regIdx == eac_pkg::IDX_OFF_NEG_STAT)
    |=> posStat_q == ($past(offPosRaw) & $past(offPosEn_q) & CH_MASK)
    && negStat_q == ($past(offNegRaw) & $past(offNegEn_q) & CH_MASK))
    else $error("status register took a write");
  pin_input_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrEn && regIdx == eac_pkg::IDX_PIN_PORT && pinDir_q == 4'hf
    |=> $stable(pinData_q))
    else $error("input pin data changed on write");
  pin_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    psel && penable && !pready && !pwrite && regIdx == eac_pkg::IDX_PIN_PORT && hit
    |=> prdata[7:4] == $past(pinIn))
    else $error("pin read did not return pin levels");
  pin_shared_a: assert property (@(posedge clk) disable iff (!rst_n)
    pinsTaken |=> (pinOe & eac_pkg::PIN_SHARED) == 4'h0)
    else $error("shared pin driven while breathing owns it");
  pin_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 (pinOe & $past(pinDir_q)) == 4'h0)
    else $error("input pin driven");
  even_route_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 $onehot0(ctrl.evenPulseCh) && (ctrl.evenPulseCh & 8'h55) == 8'h00)
    else $error("even pulse route not a single even channel");
  odd_route_a: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n && pulse_q[eac_pkg::PULSE_ODD_LSB +: 2] == 2'b00 |=> ctrl.oddPulseCh == 8'h01)
    else $error("odd code 00 did not route channel 1");
  ch_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrEn && regIdx == eac_pkg::IDX_BIAS_POS |=> biasPos_q == ($past(wByte) & CH_MASK))
    else $error("positive bias select not stored masked");

  // ==========================================================
  // stored values and their output copies; rst_n gate skips the release edge
  bias_neg_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrEn && regIdx == eac_pkg::IDX_BIAS_NEG |=> biasNeg_q == ($past(wByte) & CH_MASK))
    else $error("negative bias select not stored masked");
  sense_pos_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrEn && regIdx == eac_pkg::IDX_OFF_POS_EN |=> offPosEn_q == ($past(wByte) & CH_MASK))
    else $error("positive sense enable not stored");
  sense_neg_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrEn && regIdx == eac_pkg::IDX_OFF_NEG_EN |=> offNegEn_q == ($past(wByte) & CH_MASK))
    else $error("negative sense enable not stored");
  flip_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrEn && regIdx == eac_pkg::IDX_OFF_DIR |=> offDir_q == ($past(wByte) & CH_MASK))
    else $error("current direction not stored");
  neg_track_a: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n |=> negStat_q == ($past(offNegRaw) & $past(offNegEn_q) & CH_MASK))
    else $error("negative status not following enabled comparators");
  pulse_wr_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrEn && regIdx == eac_pkg::IDX_PULSE_SEL |=> pulse_q == ($past(wByte) & eac_pkg::MASK_PULSE))
    else $error("pulse register not stored");
  breath_wr_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrEn && regIdx == eac_pkg::IDX_BREATHING
    |=> breath_q == ($past(wByte) & eac_pkg::MASK_BREATHING))
    else $error("breathing register not stored");
  cfg_wr_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrEn && regIdx == eac_pkg::IDX_CONFIG_FOUR
    |=> cfgFour_q == ($past(wByte) & eac_pkg::MASK_CONFIG_FOUR))
    else $error("config four not stored");
  buf_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n |=> ctrl.pulseBufOn == $past(pulse_q[eac_pkg::PULSE_ON_BIT]))
    else $error("pulse buffer output wrong");
  shot_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n |=> ctrl.singleShot == $past(cfgFour_q[eac_pkg::SHOT_BIT]))
    else $error("single-shot output wrong");
  link_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n |=> ctrl.terminalToBias == $past(cfgFour_q[eac_pkg::LINK_BIT]))
    else $error("terminal link output wrong");
  pin_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n |=> pinOut == $past(pinData_q))
    else $error("pin drive level wrong");
  mode_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n |=> ctrl.breathMode == $past(breathMode))
    else $error("breathing mode output wrong");
  phase_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n |=> ctrl.breathPhase == $past(breath_q[eac_pkg::PHASE_LSB +: 3]))
    else $error("breathing phase output wrong");
  odd_onehot_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 $onehot0(ctrl.oddPulseCh) && (ctrl.oddPulseCh & 8'haa) == 8'h00)
    else $error("odd pulse route not a single odd channel");
  breath_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    breathMode != eac_pkg::MODE_INT |=> !breathCtrlA && !breathCtrlB)
    else $error("breathing pair active outside mode 10");
endmodule

// ### src/eac_breath_gen.sv
// breathing demodulation control pair generator
`timescale 1ns/1ns
module eac_breath_gen #(
  parameter int BASE_CYC = 3906
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [2:0] freqSel,
  input wire logic [2:0] phaseSel,
  input wire logic usePhase,
  output logic ctrlA,
  output logic ctrlB
);
  logic [19:0] period;
  logic [19:0] offset;
  logic [19:0] lagged;
  logic [22:0] prod;
  logic [19:0] cnt_q;

  // ==========================================================
  // period and lag of the second signal
  always_comb begin
    period = 20'(BASE_CYC) << freqSel;
    prod = 23'(period) * 23'({1'b0, phaseSel} + 4'h1);
    // lag is (code+1)/16 of a period, or half a period when phase is off
    offset = usePhase ? 20'(prod >> eac_pkg::PHASE_SHIFT) : (period >> 1);
    lagged = (cnt_q >= offset) ? (cnt_q - offset) : (cnt_q + period - offset);
  end

  // period counter; restarts whenever the generator is idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 20'h0;
    end else if (!enable || cnt_q >= period - 20'h1) begin
      cnt_q <= 20'h0;
    end else begin
      cnt_q <= cnt_q + 20'h1;
    end
  end

  // both outputs low while idle so the pins rest quiet
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlA <= 1'b0;
      ctrlB <= 1'b0;
    end else begin
      ctrlA <= enable && (cnt_q < (period >> 1));
      ctrlB <= enable && (lagged < (period >> 1));
    end
  end

  gen_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !enable |=> !ctrlA && !ctrlB) else $error("breathing outputs active while idle");
  gen_antiphase_a: assert property (@(posedge clk) disable iff (!rst_n)
    enable && !usePhase && $stable(freqSel) |=> ctrlB == !ctrlA)
    else $error("second breathing signal not in antiphase");
endmodule

// ### src/eac_pkg.sv
// shared constants and types for the auxiliary control register bank
// ==========================================================
// Contract
// - positive bias-drive select bit n adds channel n positive input to bias derivation
// - negative bias-drive select bit n adds channel n negative input to bias derivation
// - channels above the variant count are unavailable in every per-channel register
// - positive sense enable bit n turns on electrode-off detection; status valid only then
// - negative sense enable bit n turns on electrode-off detection; status valid only then
// - current direction bit n reverses detection current for channel n
// - positive status reads one per channel when electrode off; resets to zero
// - negative status reads one per channel when electrode off; resets to zero
// - pin data bits read back the present pin levels in either direction
// - pin data write drives the level only for output pins
// - pin direction bits: zero output, one input; reset is input
// - breathing mode 01 or 11 takes pins two to four from general use
// - even pulse select routes exactly one of channels 2,4,6,8; reset channel 2
// - odd pulse select routes exactly one of channels 1,3,5,7
// - pulse register bit 0 powers pulse buffer; off at reset
// - breathing phase code sets pin four lag, 22.5 degree steps; reset 135 degrees
// - phase setting has no effect below 32 kSPS output rate
// - breathing mode 00 none, 01 external (reset), 10 and 11 other
// - in mode 10 frequency code halves 64 kHz per step; phase rules by code
// - config four bit 3 selects single-shot conversion; continuous at reset
// - config four bit 2 links central terminal to bias drive; off at reset
package eac_pkg;
  // ==========================================================
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_BIAS_POS = 6'h0d;
  localparam logic [5:0] IDX_BIAS_NEG = 6'h0e;
  localparam logic [5:0] IDX_OFF_POS_EN = 6'h0f;
  localparam logic [5:0] IDX_OFF_NEG_EN = 6'h10;
  localparam logic [5:0] IDX_OFF_DIR = 6'h11;
  localparam logic [5:0] IDX_OFF_POS_STAT = 6'h12;
  localparam logic [5:0] IDX_OFF_NEG_STAT = 6'h13;
  localparam logic [5:0] IDX_PIN_PORT = 6'h14;
  localparam logic [5:0] IDX_PULSE_SEL = 6'h15;
  localparam logic [5:0] IDX_BREATHING = 6'h16;
  localparam logic [5:0] IDX_CONFIG_FOUR = 6'h17;
  // ==========================================================
  // reset values and writable-bit masks
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [3:0] RST_PIN_DIR = 4'hf;
  localparam logic [7:0] RST_PULSE = 8'h00;
  localparam logic [7:0] RST_BREATHING = 8'h15;
  localparam logic [7:0] RST_CONFIG_FOUR = 8'h00;
  localparam logic [7:0] MASK_PULSE = 8'h1f;
  localparam logic [7:0] MASK_BREATHING = 8'h1f;
  localparam logic [7:0] MASK_CONFIG_FOUR = 8'hee;
  // ==========================================================
  // field positions
  localparam int PIN_DATA_LSB = 4;
  localparam int PULSE_EVEN_LSB = 3;
  localparam int PULSE_ODD_LSB = 1;
  localparam int PULSE_ON_BIT = 0;
  localparam int PHASE_LSB = 2;
  localparam int MODE_LSB = 0;
  localparam int FREQ_LSB = 5;
  localparam int SHOT_BIT = 3;
  localparam int LINK_BIT = 2;
  localparam int CMP_BIT = 1;
  // ==========================================================
  // breathing modes and pin sharing
  localparam logic [1:0] MODE_NONE = 2'b00;
  localparam logic [1:0] MODE_EXT = 2'b01;
  localparam logic [1:0] MODE_INT = 2'b10;
  localparam logic [1:0] MODE_RSV = 2'b11;
  localparam logic [3:0] PIN_SHARED = 4'he;
  localparam logic [2:0] FREQ_PHASED_MAX = 3'h1;
  // ==========================================================
  // timing: clock rate and fastest breathing control frequency
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned BREATH_BASE_HZ = 64_000;
  localparam int unsigned BREATH_BASE_CYC = CLK_HZ / BREATH_BASE_HZ;
  localparam int PHASE_SHIFT = 4;
  // ==========================================================
  // control outputs toward the analog side
  typedef struct packed {
    logic [7:0] biasPos;
    logic [7:0] biasNeg;
    logic [7:0] offPosEn;
    logic [7:0] offNegEn;
    logic [7:0] offDir;
    logic [7:0] evenPulseCh;
    logic [7:0] oddPulseCh;
    logic pulseBufOn;
    logic [1:0] breathMode;
    logic [2:0] breathPhase;
    logic [2:0] breathFreq;
    logic singleShot;
    logic terminalToBias;
    logic comparatorOn;
  } eac_ctrl_t;
endpackage

// ### test/tb_ecg_afe_aux_control_regs.sv
// self-checking bench for the auxiliary control register bank
`timescale 1ns/1ns
module tb_ecg_afe_aux_control_regs;
  // ==========================================================
  // stimulus and observed signals
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] offPosRaw = 8'h00;
  logic [7:0] offNegRaw = 8'h00;
  logic fastRate = 1'h1;
  logic [3:0] pinIn = 4'h0;
  logic [3:0] pinOut;
  logic [3:0] pinOe;
  eac_pkg::eac_ctrl_t ctrl;
  logic breathCtrlA;
  logic breathCtrlB;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int checkCount = 0;
  logic [7:0] pat [5] = '{8'h81, 8'h42, 8'h3c, 8'hc3, 8'h96};

  // free-running 250 MHz clock
  always #2 clk = ~clk;

  // short breathing period keeps the waveform checks brief
  eac_aux_regs #(.CHANNELS(8), .BREATH_PERIOD_CYC(16)) uut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .offPosRaw(offPosRaw), .offNegRaw(offNegRaw),
    .fastRate(fastRate), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .ctrl(ctrl), .breathCtrlA(breathCtrlA), .breathCtrlB(breathCtrlB)
  );

  // ==========================================================
  // shared helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one apb transfer; waits for its own edge so releases never collide
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    apb(1'h1, {idx, 2'h0}, d);
  endtask

  task automatic rdc(input string what, input logic [5:0] idx, input logic [7:0] exp);
    apb(1'h0, {idx, 2'h0}, 8'h00);
    chk(what, {24'h0, exp}, rd);
  endtask

  // control outputs lag the register by one edge
  task automatic settle();
    @(posedge clk);
    @(negedge clk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [7:0] e [11] = '{0, 0, 0, 0, 0, 0, 0, 8'h0f, 0, 8'h15, 0};
    for (int i = 0; i < 11; i++) begin
      rdc("resetValue", 6'h0d + 6'(i), e[i]);
    end
    chk("mode", 32'h1, ctrl.breathMode);
    chk("phase", 32'h5, ctrl.breathPhase);
    chk("evenCh", 32'h2, ctrl.evenPulseCh);
    chk("oddCh", 32'h1, ctrl.oddPulseCh);
    chk("oe", 32'h0, pinOe);
    $display("test reset done");
  endtask

  // all five per-channel registers written first to expose aliasing
  task automatic t_chan();
    for (int i = 0; i < 5; i++) wr(6'h0d + 6'(i), pat[i]);
    for (int i = 0; i < 5; i++) begin
      rdc("chanReg", 6'h0d + 6'(i), pat[i]);
    end
    settle();
    chk("biasPos", pat[0], ctrl.biasPos);
    chk("biasNeg", pat[1], ctrl.biasNeg);
    chk("offPosEn", pat[2], ctrl.offPosEn);
    chk("offNegEn", pat[3], ctrl.offNegEn);
    chk("offDir", pat[4], ctrl.offDir);
    $display("test channels done");
  endtask

  task automatic t_status();
    @(posedge clk);
    offPosRaw <= 8'hff;
    offNegRaw <= 8'h55;
    settle();
    rdc("posStat", 6'h12, 8'h3c);
    rdc("negStat", 6'h13, 8'h41);
    wr(6'h12, 8'hff);
    wr(6'h13, 8'h00);
    rdc("posStatWr", 6'h12, 8'h3c);
    rdc("negStatWr", 6'h13, 8'h41);
    offPosRaw <= 8'h00;
    offNegRaw <= 8'h00;
    settle();
    rdc("posStatOn", 6'h12, 8'h00);
    $display("test status done");
  endtask

  // data bits land only on pins already set as outputs
  task automatic t_pins();
    wr(6'h16, 8'h14);
    wr(6'h14, 8'ha3);
    settle();
    chk("outFromIn", 32'h0, pinOut);
    chk("oe", 32'hc, pinOe);
    wr(6'h14, 8'ha3);
    pinIn <= 4'h5;
    settle();
    chk("outDrive", 32'h8, pinOut);
    rdc("pinRead", 6'h14, 8'h53);
    wr(6'h16, 8'h15);
    settle();
    chk("oeExt", 32'h0, pinOe);
    wr(6'h16, 8'h17);
    settle();
    chk("oeRsv", 32'h0, pinOe);
    wr(6'h16, 8'h14);
    settle();
    chk("oeFree", 32'hc, pinOe);
    $display("test pins done");
  endtask

  task automatic t_pulse();
    for (int k = 0; k < 4; k++) begin
      wr(6'h15, {3'h0, 2'(k), 2'(k), 1'h1});
      settle();
      chk("evenCh", 32'h1 << (2 * k + 1), ctrl.evenPulseCh);
      chk("oddCh", 32'h1 << (2 * k), ctrl.oddPulseCh);
      chk("bufOn", 32'h1, ctrl.pulseBufOn);
    end
    wr(6'h15, 8'h1f);
    rdc("pulseRsv", 6'h15, 8'h1f);
    wr(6'h15, 8'h00);
    settle();
    chk("bufOff", 32'h0, ctrl.pulseBufOn);
    $display("test pulse done");
  endtask

  task automatic t_cfg4();
    wr(6'h17, 8'hee);
    rdc("cfgRsv", 6'h17, 8'hee);
    settle();
    chk("shot", 32'h1, ctrl.singleShot);
    chk("link", 32'h1, ctrl.terminalToBias);
    chk("cmp", 32'h1, ctrl.comparatorOn);
    wr(6'h17, 8'h00);
    settle();
    chk("shotOff", 32'h0, ctrl.singleShot);
    chk("linkOff", 32'h0, ctrl.terminalToBias);
    chk("cmpOff", 32'h0, ctrl.comparatorOn);
    $display("test config four done");
  endtask

  // B must be A delayed by lag cycles; A high half of each period
  task automatic t_breath(input logic [2:0] fq, input logic fast, input int lag);
    logic [127:0] hist;
    int hi;
    int bad;
    hist = '0;
    hi = 0;
    bad = 0;
    wr(6'h17, {fq, 5'h00});
    fastRate <= fast;
    wr(6'h16, 8'h16);
    for (int c = 0; c < 256; c++) begin
      @(negedge clk);
      hist = {hist[126:0], breathCtrlA};
      if (c >= 128 && breathCtrlA === 1'h1) hi++;
      if (c >= 128 && breathCtrlB !== hist[lag]) bad++;
    end
    chk("highCycles", 32'd64, hi);
    chk("freq", {29'h0, fq}, ctrl.breathFreq);
    chk("lagErrors", 32'h0, bad);
    wr(6'h16, 8'h14);
    settle();
    chk("idleA", 32'h0, breathCtrlA);
    chk("idleB", 32'h0, breathCtrlB);
    $display("test breathing done");
  endtask

  task automatic t_err();
    apb(1'h0, 8'h30, 8'h00);
    chk("lowErr", 32'h1, err);
    chk("lowData", 32'h0, rd);
    apb(1'h1, 8'h60, 8'hff);
    chk("highErr", 32'h1, err);
    apb(1'h1, 8'h35, 8'hff);
    chk("alignErr", 32'h1, err);
    rdc("kept", 6'h0d, pat[0]);
    chk("okErr", 32'h0, err);
    $display("test errors done");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_chan();
    t_status();
    t_pins();
    t_pulse();
    t_cfg4();
    t_breath(3'h0, 1'h1, 6);
    t_breath(3'h0, 1'h0, 8);
    t_breath(3'h2, 1'h1, 32);
    t_err();
    summarize();
  end
endmodule
